/* hw/rmdc_map.svh */
// Purpose: Constants for the receiver mode and data clock block.
// Assumes: mclk_in runs at 25 MHz; the link clock period is given below.
// Notes: Counts derive from times; counts above 4096 cycles are top parameters.
// Summary of operation
// - Passed bit check enters receiving, drives data.
// - Receiving persists until explicit return to polling.
// - Demodulator sampled on extended clock ticks only.
// - Data edges never closer than minimum spacing.
// - Data low released after maximum low duration.
// - After stream: high or noise, per enable.
// - Overlong host low resets both configuration registers.
// - Off frame bit one: one sync, then sleep.
// - Poll pin low, rise, delay: polling again.
// - Poll pin low wakes device, ignoring settings.
// - Shift clock only for Manchester or Bi-phase streams.
// - Recovery accepts only single and double intervals.
// - Single window uses bit-check limits.
// - Double window: sum minus/plus half difference, up.
// - Clock starts after double start bit, delayed.
// - Code error stops clock, reruns bit check unless forced or zero checks.
// - Zero checks or forced: clock at start bit.
// - Bi-phase clock edge at end of bit.
// - Clock after pin level matches, plus delay.
// - Out-of-window interval ends first check, back to sleep.
// - Noise suppress: coded stream end reruns check unless forced or zero checks, data high.
`ifndef RMDC_MAP_SVH
`define RMDC_MAP_SVH
`define RMDC_MCLK_KHZ 25000
`define RMDC_XDIV_BR0 8'h40
`define RMDC_XDIV_BR1 8'h20
`define RMDC_XDIV_BR2 8'h10
`define RMDC_XDIV_BR3 8'h08
`define RMDC_DATA_MIN_TICKS 8'h08
`define RMDC_DATA_LMAX_TICKS 8'hc8
`define RMDC_OFF_MIN_TICKS 8'h50
`define RMDC_OFF_MAX_TICKS 8'hf0
`define RMDC_SYNC_TICKS 8'h0a
`define RMDC_BIT_TICKS 8'h14
`define RMDC_SLEEP_PERM 5'h1f
`define RMDC_WAKE_DELAY_US 100
`define RMDC_RELEASE_LOW_US 50
`define RMDC_POLL_RESUME_US 100
`define RMDC_STARTUP_US 1000
`define RMDC_SLEEP_UNIT_CYC 2048
`define RMDC_US2CYC(t) (((t) * `RMDC_MCLK_KHZ + 999) / 1000)
`define RMDC_LINK_PERIOD_NS 6
`define RMDC_DELAY2_NS 60
`define RMDC_DELAY2_CYC (((`RMDC_DELAY2_NS) + (`RMDC_LINK_PERIOD_NS) - 1) / (`RMDC_LINK_PERIOD_NS))
`endif

/* hw/rmdc_pkg.sv */
// Purpose: Types shared by the receiver mode and data clock block.
// Assumes: Constants come from rmdc_map.svh.
// Notes: States use Gray codes along the usual path.
package rmdc_pkg;
  // Main operating state.
  typedef enum logic [2:0] {
    RMDC_SLEEP = 3'h0,
    RMDC_STARTUP = 3'h1,
    RMDC_CHECK = 3'h3,
    RMDC_RECEIVE = 3'h2,
    RMDC_RECHECK = 3'h6
  } rmdc_state_t;
  // Off command stage on the shared data line.
  typedef enum logic [1:0] {
    RMDC_OFF_IDLE = 2'h0,
    RMDC_OFF_LOW = 2'h1,
    RMDC_OFF_SYNC = 2'h3,
    RMDC_OFF_BIT = 2'h2
  } rmdc_off_t;
  // Configuration words held outside this block.
  typedef struct packed {
    logic [1:0] baud_range_select;
    logic [1:0] check_bit_count;
    logic coded_stream;
    logic [4:0] sleep;
    logic noise_disable;
    logic [5:0] lim_min;
    logic [5:0] lim_max;
  } rmdc_cfg_t;
endpackage

/* hw/rmdc_top.sv */
// Purpose: Receiving mode control, data conditioning and shift clock recovery.
// Assumes: Shared data line is open drain with an external pull-up.
// Notes: Link-side logic runs on link_clk_in; crossings use synchronisers.
`timescale 1ns/1ps
`default_nettype none
`include "rmdc_map.svh"
module rmdc_top #(
  parameter int STARTUP_CYC = `RMDC_US2CYC(`RMDC_STARTUP_US),
  parameter int SLEEP_UNIT_CYC = `RMDC_SLEEP_UNIT_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic link_clk_in,
  input wire rmdc_pkg::rmdc_cfg_t cfg_in,
  input wire logic dem_in,
  input wire logic poll_on_n_in,
  input wire logic data_i_in,
  output logic data_o_out,
  output logic data_oe_out,
  output logic data_clk_out,
  output logic ic_active_out,
  output logic rx_mode_out,
  output logic cfg_reset_out
);
  // ---------------------------------------------------------------
  // Constants
  // ---------------------------------------------------------------
  // Wait times in mclk cycles, DLY2_CYC in link_clk_in cycles, all below the parameter threshold.
  localparam logic [15:0] WAKE_CYC = 16'(`RMDC_US2CYC(`RMDC_WAKE_DELAY_US));
  localparam logic [15:0] REL_CYC = 16'(`RMDC_US2CYC(`RMDC_RELEASE_LOW_US));
  localparam logic [15:0] RES_CYC = 16'(`RMDC_US2CYC(`RMDC_POLL_RESUME_US));
  localparam logic [3:0] DLY2_CYC = 4'(`RMDC_DELAY2_CYC);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] dem_sync_reg; // Demodulator output into mclk.
  logic [1:0] poll_sync_reg; // Polling-control pin into mclk.
  logic [1:0] pin_sync_reg; // Data line level into mclk.
  // Each pin passes two flops; only the second one is read.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      dem_sync_reg <= 2'h3;
      poll_sync_reg <= 2'h3;
      pin_sync_reg <= 2'h3;
    end else begin
      dem_sync_reg <= {dem_sync_reg[0], dem_in};
      poll_sync_reg <= {poll_sync_reg[0], poll_on_n_in};
      pin_sync_reg <= {pin_sync_reg[0], data_i_in};
    end
  end
  logic poll_low;
  logic pin_level;
  assign poll_low = ~poll_sync_reg[1];
  assign pin_level = pin_sync_reg[1];

  // ---------------------------------------------------------------
  // Extended clock tick
  // ---------------------------------------------------------------
  logic [7:0] xdiv; // Cycles per tick for the baud range.
  logic [7:0] xcnt_reg; // Divider count.
  logic xtick; // One-cycle tick of the extended clock.
  always_comb begin
    unique case (cfg_in.baud_range_select)
      2'h0: xdiv = `RMDC_XDIV_BR0;
      2'h1: xdiv = `RMDC_XDIV_BR1;
      2'h2: xdiv = `RMDC_XDIV_BR2;
      2'h3: xdiv = `RMDC_XDIV_BR3;
    endcase
  end
  assign xtick = (xcnt_reg >= xdiv - 8'h01);
  // Free-running divider; a range change takes effect within one tick.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      xcnt_reg <= 8'h00;
    end else begin
      xcnt_reg <= xtick ? 8'h00 : xcnt_reg + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Data conditioning
  // ---------------------------------------------------------------
  logic data_reg; // Conditioned internal data signal.
  logic [7:0] ee_cnt_reg; // Ticks since the last data edge.
  logic data_edge; // Data toggles at this tick.
  logic low_limit; // Low lasted the longest allowed time.
  assign low_limit = ~data_reg && (ee_cnt_reg >= `RMDC_DATA_LMAX_TICKS - 8'h01);
  // Short spikes are held off until the spacing has passed.
  assign data_edge = xtick && (ee_cnt_reg >= `RMDC_DATA_MIN_TICKS - 8'h01)
    && ((dem_sync_reg[1] != data_reg) || low_limit);
  // Data and edge counter move only on ticks, so spacings are whole ticks.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      data_reg <= 1'b1;
      ee_cnt_reg <= 8'h00;
    end else if (xtick) begin
      if (data_edge) begin
        data_reg <= ~data_reg;
        ee_cnt_reg <= 8'h00;
      end else if (ee_cnt_reg != 8'hff) begin
        ee_cnt_reg <= ee_cnt_reg + 8'h01;
      end
    end
  end
  // Interval measured at an edge, counting the edge tick itself.
  logic [6:0] ivl;
  assign ivl = (ee_cnt_reg >= 8'h3f) ? 7'h7f : {1'b0, ee_cnt_reg[5:0] + 6'h01};

  // ---------------------------------------------------------------
  // Interval windows
  // ---------------------------------------------------------------
  logic [6:0] sum_lim; // Lower plus upper bound.
  logic [6:0] dif_lim; // Upper minus lower bound.
  logic [6:0] lo2; // Double window lower bound.
  logic [6:0] hi2; // Double window upper bound.
  logic in_t; // Interval fits the single window.
  logic in_2t; // Interval fits the double window.
  logic too_long; // No edge by the 64th tick since the last one.
  assign sum_lim = {1'b0, cfg_in.lim_min} + {1'b0, cfg_in.lim_max};
  assign dif_lim = {1'b0, cfg_in.lim_max} - {1'b0, cfg_in.lim_min};
  // Subtracting the floor and adding the ceiling rounds both results up.
  assign lo2 = sum_lim - {1'b0, dif_lim[6:1]};
  assign hi2 = sum_lim + {1'b0, dif_lim[6:1]} + {6'h00, dif_lim[0]};
  assign in_t = (ivl >= {1'b0, cfg_in.lim_min})
    && (ivl < {1'b0, cfg_in.lim_max});
  assign in_2t = (ivl >= lo2) && (ivl < hi2);
  assign too_long = xtick && !data_edge && (ee_cnt_reg >= 8'h3f);

  // ---------------------------------------------------------------
  // Mode state
  // ---------------------------------------------------------------
  rmdc_pkg::rmdc_state_t state_reg;
  rmdc_pkg::rmdc_off_t off_reg;
  logic [4:0] need_edges; // Edge checks asked for by the count.
  logic [4:0] ok_cnt_reg; // Edge checks passed so far.
  logic [15:0] wait_reg; // Startup, sleep and pin delay counter.
  logic [4:0] unit_reg; // Sleep units elapsed.
  logic forced_reg; // Reception forced by the polling pin.
  logic started_reg; // Start bit seen; shift clock running.
  logic half_reg; // First of two single intervals seen.
  logic clk_tgl_reg; // Toggles once per shift clock edge.
  logic go_sleep; // Off command or pin command completes.
  logic rec_err; // Timing error or code violation.
  logic [15:0] plow_reg; // Polling pin low duration.
  logic plow_armed_reg; // Pin held low long enough to release.
  logic presume_reg; // Resume delay running.
  logic [7:0] off_cnt_reg; // Off command tick counter.
  logic sync_drv_reg; // Device drives the sync pulse.

  // Three, six or nine bits mean six, twelve or eighteen edge checks.
  always_comb begin
    unique case (cfg_in.check_bit_count)
      2'h0: need_edges = 5'h00;
      2'h1: need_edges = 5'h06;
      2'h2: need_edges = 5'h0c;
      2'h3: need_edges = 5'h12;
    endcase
  end

  // Recovery error while receiving: bad interval or double after half.
  assign rec_err = (state_reg == rmdc_pkg::RMDC_RECEIVE)
    && ((data_edge && (!(in_t || in_2t) || (in_2t && half_reg)))
    || (too_long && started_reg));

  // Main sequence of sleep, start-up, check and reception.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= rmdc_pkg::RMDC_SLEEP;
      ok_cnt_reg <= 5'h00;
      wait_reg <= 16'h0000;
      unit_reg <= 5'h00;
      forced_reg <= 1'b0;
    end else if (go_sleep) begin
      state_reg <= rmdc_pkg::RMDC_SLEEP;
      wait_reg <= 16'h0000;
      unit_reg <= 5'h00;
      forced_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        rmdc_pkg::RMDC_SLEEP: begin
          wait_reg <= wait_reg + 16'h0001;
          if (poll_low) begin
            // Sleep field is ignored but kept while the pin is low.
            if (wait_reg >= WAKE_CYC - 16'h0001) begin
              state_reg <= rmdc_pkg::RMDC_STARTUP;
              wait_reg <= 16'h0000;
              forced_reg <= 1'b1;
            end
          end else if (cfg_in.sleep == `RMDC_SLEEP_PERM) begin
            wait_reg <= 16'h0000;
          end else if (unit_reg >= cfg_in.sleep) begin
            state_reg <= rmdc_pkg::RMDC_STARTUP;
            wait_reg <= 16'h0000;
            forced_reg <= 1'b0;
          end else if (wait_reg >= 16'(SLEEP_UNIT_CYC - 1)) begin
            wait_reg <= 16'h0000;
            unit_reg <= unit_reg + 5'h01;
          end
        end
        rmdc_pkg::RMDC_STARTUP: begin
          wait_reg <= wait_reg + 16'h0001;
          ok_cnt_reg <= 5'h00;
          unit_reg <= 5'h00;
          if (wait_reg >= 16'(STARTUP_CYC - 1)) begin
            // Forced reception or a zero count skips the check.
            if (forced_reg || need_edges == 5'h00) begin
              state_reg <= rmdc_pkg::RMDC_RECEIVE;
            end else begin
              state_reg <= rmdc_pkg::RMDC_CHECK;
            end
          end
        end
        rmdc_pkg::RMDC_CHECK, rmdc_pkg::RMDC_RECHECK: begin
          if ((data_edge && !in_t) || too_long) begin
            ok_cnt_reg <= 5'h00;
            // The first check fails to sleep; a recheck keeps trying.
            if (state_reg == rmdc_pkg::RMDC_CHECK) begin
              state_reg <= rmdc_pkg::RMDC_SLEEP;
              wait_reg <= 16'h0000;
            end
          end else if (data_edge) begin
            ok_cnt_reg <= ok_cnt_reg + 5'h01;
            if (ok_cnt_reg + 5'h01 >= need_edges) begin
              state_reg <= rmdc_pkg::RMDC_RECEIVE;
            end
          end
        end
        rmdc_pkg::RMDC_RECEIVE: begin
          ok_cnt_reg <= 5'h00;
          // Besides go_sleep, only an error leaves, and only to a recheck.
          if (rec_err && !forced_reg && need_edges != 5'h00) begin
            state_reg <= rmdc_pkg::RMDC_RECHECK;
          end
        end
        default: state_reg <= rmdc_pkg::RMDC_SLEEP;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Shift clock recovery
  // ---------------------------------------------------------------
  // Edges come at a double interval or at the second of two singles,
  // which is the end of the bit for Bi-phase as well.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      started_reg <= 1'b0;
      half_reg <= 1'b0;
      clk_tgl_reg <= 1'b0;
    end else if (state_reg != rmdc_pkg::RMDC_RECEIVE || rec_err || go_sleep) begin
      started_reg <= 1'b0;
      half_reg <= 1'b0;
    end else if (data_edge && cfg_in.coded_stream) begin
      if (!started_reg) begin
        if (in_2t) begin
          started_reg <= 1'b1;
          clk_tgl_reg <= ~clk_tgl_reg;
        end
      end else if (in_2t) begin
        clk_tgl_reg <= ~clk_tgl_reg;
      end else if (half_reg) begin
        half_reg <= 1'b0;
        clk_tgl_reg <= ~clk_tgl_reg;
      end else begin
        half_reg <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Off command over the data line
  // ---------------------------------------------------------------
  logic host_low; // Line low while the device releases it.
  logic [1:0] oe_hist_reg; // Drive enable of the last two cycles.
  // The sensed level lags the drive by two flops, so a fresh release is masked.
  assign host_low = ~pin_level && ~data_oe_out && ~|oe_hist_reg;
  // A long host low, one sync pulse, then a first bit of one means off.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      off_reg <= rmdc_pkg::RMDC_OFF_IDLE;
      off_cnt_reg <= 8'h00;
      sync_drv_reg <= 1'b0;
      cfg_reset_out <= 1'b0;
    end else begin
      cfg_reset_out <= 1'b0;
      unique case (off_reg)
        rmdc_pkg::RMDC_OFF_IDLE: begin
          off_cnt_reg <= 8'h00;
          // A recheck is still receiving mode, so the off command is taken there too.
          if (host_low && (state_reg == rmdc_pkg::RMDC_RECEIVE
            || state_reg == rmdc_pkg::RMDC_RECHECK)) begin
            off_reg <= rmdc_pkg::RMDC_OFF_LOW;
          end
        end
        rmdc_pkg::RMDC_OFF_LOW: begin
          if (xtick && off_cnt_reg != 8'hff) begin
            off_cnt_reg <= off_cnt_reg + 8'h01;
          end
          if (xtick && off_cnt_reg == `RMDC_OFF_MAX_TICKS) begin
            cfg_reset_out <= 1'b1;
          end
          if (pin_level) begin
            off_cnt_reg <= 8'h00;
            if (off_cnt_reg >= `RMDC_OFF_MIN_TICKS) begin
              off_reg <= rmdc_pkg::RMDC_OFF_SYNC;
              sync_drv_reg <= 1'b1;
            end else begin
              off_reg <= rmdc_pkg::RMDC_OFF_IDLE;
            end
          end
        end
        rmdc_pkg::RMDC_OFF_SYNC: begin
          if (xtick) begin
            off_cnt_reg <= off_cnt_reg + 8'h01;
          end
          if (xtick && off_cnt_reg >= `RMDC_SYNC_TICKS - 8'h01) begin
            sync_drv_reg <= 1'b0;
            off_cnt_reg <= 8'h00;
            off_reg <= rmdc_pkg::RMDC_OFF_BIT;
          end
        end
        rmdc_pkg::RMDC_OFF_BIT: begin
          if (xtick) begin
            off_cnt_reg <= off_cnt_reg + 8'h01;
          end
          // A host low here is a programming frame, handled elsewhere.
          if (host_low) begin
            off_reg <= rmdc_pkg::RMDC_OFF_IDLE;
          end else if (xtick && off_cnt_reg >= `RMDC_BIT_TICKS - 8'h01) begin
            off_reg <= rmdc_pkg::RMDC_OFF_IDLE;
          end
        end
        default: off_reg <= rmdc_pkg::RMDC_OFF_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Return to polling by the polling-control pin
  // ---------------------------------------------------------------
  // Low for the release time arms; the rise starts the resume delay.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      plow_reg <= 16'h0000;
      plow_armed_reg <= 1'b0;
      presume_reg <= 1'b0;
    end else if (presume_reg) begin
      plow_reg <= plow_reg + 16'h0001;
      if (plow_reg >= RES_CYC - 16'h0001 || poll_low) begin
        presume_reg <= 1'b0;
        plow_reg <= 16'h0000;
      end
    end else if (poll_low && state_reg != rmdc_pkg::RMDC_SLEEP) begin
      if (plow_reg >= REL_CYC - 16'h0001) begin
        plow_armed_reg <= 1'b1;
      end else begin
        plow_reg <= plow_reg + 16'h0001;
      end
    end else begin
      presume_reg <= plow_armed_reg && !poll_low;
      plow_armed_reg <= 1'b0;
      plow_reg <= 16'h0000;
    end
  end
  assign go_sleep = (presume_reg && plow_reg >= RES_CYC - 16'h0001 && !poll_low)
    || (off_reg == rmdc_pkg::RMDC_OFF_BIT && !host_low && xtick
    && off_cnt_reg >= `RMDC_BIT_TICKS - 8'h01);

  // ---------------------------------------------------------------
  // Data line drive and status
  // ---------------------------------------------------------------
  logic route; // Internal data steers the line.
  // Noise passes on a recheck only when suppression is off.
  assign route = (state_reg == rmdc_pkg::RMDC_RECEIVE)
    || (state_reg == rmdc_pkg::RMDC_RECHECK && !cfg_in.noise_disable);
  // Drive is registered; the line is only ever pulled low.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      data_oe_out <= 1'b0;
      oe_hist_reg <= 2'h0;
      ic_active_out <= 1'b0;
      rx_mode_out <= 1'b0;
    end else begin
      data_oe_out <= sync_drv_reg || (route && !data_reg
        && off_reg == rmdc_pkg::RMDC_OFF_IDLE && !host_low);
      oe_hist_reg <= {oe_hist_reg[0], data_oe_out};
      ic_active_out <= (state_reg != rmdc_pkg::RMDC_SLEEP);
      rx_mode_out <= (state_reg == rmdc_pkg::RMDC_RECEIVE)
        || (state_reg == rmdc_pkg::RMDC_RECHECK);
    end
  end
  assign data_o_out = 1'b0;

  // ---------------------------------------------------------------
  // Link domain: shift clock pin
  // ---------------------------------------------------------------
  logic [2:0] tgl_sync_reg; // Clock event toggle into link domain.
  logic [1:0] drv_sync_reg; // Driven level into link domain.
  logic [1:0] lpin_sync_reg; // Sensed level into link domain.
  logic pend_reg; // Clock edge waiting for the line.
  logic [3:0] dly_reg; // Extra delay after levels agree.
  // The driven level is the inverse of the enable on an open drain.
  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tgl_sync_reg <= 3'h0;
      drv_sync_reg <= 2'h3;
      lpin_sync_reg <= 2'h3;
    end else begin
      tgl_sync_reg <= {tgl_sync_reg[1:0], clk_tgl_reg};
      drv_sync_reg <= {drv_sync_reg[0], ~data_oe_out};
      lpin_sync_reg <= {lpin_sync_reg[0], data_i_in};
    end
  end
  // Heavy line load delays the clock; the edge waits for agreement.
  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_reg <= 1'b0;
      dly_reg <= 4'h0;
      data_clk_out <= 1'b0;
    end else begin
      if (tgl_sync_reg[2] != tgl_sync_reg[1]) begin
        pend_reg <= 1'b1;
        dly_reg <= 4'h0;
      end else if (pend_reg && drv_sync_reg[1] == lpin_sync_reg[1]) begin
        dly_reg <= dly_reg + 4'h1;
        if (dly_reg >= DLY2_CYC - 4'h1) begin
          pend_reg <= 1'b0;
          data_clk_out <= ~data_clk_out;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* sim/rmdc_host.sv */
// Purpose: Host microcontroller model on the shared data line.
// Assumes: The line has a pull-up and each party only pulls it low.
// Notes: A pull starts only on a high line, so device activity is never masked.
`timescale 1ns/1ps
`default_nettype none
module rmdc_host (
  input wire logic mclk_in,
  input wire logic pull_req_in,
  input wire logic dev_oe_in,
  output logic line_out
);
  logic pull_reg = 1'h0; // High while the host pulls the line low.
  // Sense the line before pulling, as a real host would.
  always @(posedge mclk_in) begin
    if (!pull_req_in) pull_reg <= 1'h0;
    else if (line_out) pull_reg <= 1'h1;
  end
  // Wired low: any puller wins, otherwise the pull-up sets a high level.
  assign line_out = !(pull_reg || dev_oe_in);
endmodule
`default_nettype wire

/* sim/rmdc_top_assertions.sv */
// Purpose: Concurrent checks on the ports of rmdc_top.
// Assumes: Tick length follows the baud range select field.
// Notes: Long spans are counted in helper registers, not repetitions.
`timescale 1ns/1ps
`default_nettype none
module rmdc_top_assertions (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic link_clk_in,
  input wire rmdc_pkg::rmdc_cfg_t cfg_in,
  input wire logic poll_on_n_in,
  input wire logic data_i_in,
  input wire logic data_o_out,
  input wire logic data_oe_out,
  input wire logic data_clk_out,
  input wire logic ic_active_out,
  input wire logic rx_mode_out,
  input wire logic cfg_reset_out
);
  logic [15:0] xdiv; // Tick length in main clock cycles.
  logic [15:0] gap_reg; // Cycles since the last driven edge.
  logic [15:0] low_reg; // Cycles the device has held the line low.
  assign xdiv = 16'h0040 >> cfg_in.baud_range_select;
  // Starts saturated so the first edge after reset is never judged short.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) gap_reg <= 16'hffff;
    else if ($changed(data_oe_out)) gap_reg <= 16'h0001;
    else if (gap_reg != 16'hffff) gap_reg <= gap_reg + 16'h0001;
  end
  // Counts the current low drive.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) low_reg <= 16'h0000;
    else low_reg <= data_oe_out ? low_reg + 16'h0001 : 16'h0000;
  end
  drive_low_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    data_o_out == 1'h0) else $error("data output not held low");
  edge_space_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    $changed(data_oe_out) |-> gap_reg >= (xdiv << 3)) else $error("data edges too close");
  low_limit_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    data_oe_out |-> low_reg <= xdiv * 16'h00c9) else $error("data low too long");
  sleep_quiet_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    !rx_mode_out && !$past(rx_mode_out) |-> !data_oe_out) else $error("drive outside rx");
  rx_exit_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    $fell(rx_mode_out) |-> !ic_active_out) else $error("rx left without sleep");
  perm_sleep_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    poll_on_n_in [*4] ##0 (cfg_in.sleep == 5'h1f && !ic_active_out) |=> !ic_active_out)
    else $error("woke from permanent sleep");
  cfg_pulse_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    cfg_reset_out |-> !data_i_in ##1 !cfg_reset_out) else $error("bad config reset pulse");
  clk_coded_a: assert property (@(posedge link_clk_in) disable iff (rst_in)
    $changed(data_clk_out) |-> cfg_in.coded_stream) else $error("shift clock when uncoded");
  clk_rx_a: assert property (@(posedge link_clk_in) disable iff (rst_in)
    $changed(data_clk_out) |-> rx_mode_out) else $error("shift clock outside rx");
  rx_entry_c: cover property (@(posedge mclk_in) disable iff (rst_in) $rose(rx_mode_out));
  cfg_clear_c: cover property (@(posedge mclk_in) disable iff (rst_in) cfg_reset_out);
  clk_edge_c: cover property (@(posedge link_clk_in) disable iff (rst_in) $changed(data_clk_out));
endmodule
bind rmdc_top rmdc_top_assertions i_chk (.mclk_in, .rst_in, .link_clk_in, .cfg_in, .poll_on_n_in,
  .data_i_in, .data_o_out, .data_oe_out, .data_clk_out, .ic_active_out, .rx_mode_out,
  .cfg_reset_out);
`default_nettype wire

/* sim/rmdc_top_bench.sv */
// Purpose: Self-checking bench for rmdc_top with a host model.
// Assumes: Small startup and sleep counts; fastest baud range, 8 cycles a tick.
// Notes: State pairs {active, rx} are queued by the driver and checked by a monitor.
`timescale 1ns/1ps
`default_nettype none
module rmdc_top_bench;
  logic mclk_in = 1'h0, lclk = 1'h0, rst_in = 1'h1, dem = 1'h1, poll_n = 1'h1, pull = 1'h0;
  logic oe, dclk, ic, rx, cres, line, dout;
  rmdc_pkg::rmdc_cfg_t cfg = {2'h3, 2'h0, 1'h1, 5'h1f, 1'h1, 6'h0a, 6'h0e};
  logic [1:0] expq[$]; // Expected state pairs, oldest first.
  logic [1:0] prev = 2'h0;
  int miscompares = 0, compares = 0, clk_edges = 0, resets = 0, seed = 78394;
  initial forever #20 mclk_in = !mclk_in;
  // Link clock starts off phase so the two domains never line up.
  initial begin
    #1.7;
    forever #3 lclk = !lclk;
  end
  rmdc_top #(.STARTUP_CYC(20), .SLEEP_UNIT_CYC(16)) i_dut (.mclk_in(mclk_in), .rst_in(rst_in),
    .link_clk_in(lclk), .cfg_in(cfg), .dem_in(dem), .poll_on_n_in(poll_n), .data_i_in(line),
    .data_o_out(dout), .data_oe_out(oe), .data_clk_out(dclk), .ic_active_out(ic),
    .rx_mode_out(rx), .cfg_reset_out(cres));
  rmdc_host i_host (.mclk_in(mclk_in), .pull_req_in(pull), .dev_oe_in(oe), .line_out(line));
  task automatic chk_state(input logic [1:0] e, input logic [1:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("Error state exp %h got %h", e, g);
    end
  endtask
  task automatic chk_count(input string n, input int e, input int g);
    compares++;
    if (g != e) begin
      miscompares++;
      $display("Error %s exp %0d got %0d", n, e, g);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Each change of the state pair takes the oldest note off the queue.
  always @(posedge mclk_in) begin
    if (!rst_in && {ic, rx} !== prev) begin
      prev = {ic, rx};
      chk_state(expq.size() > 0 ? expq.pop_front() : 2'hx, prev);
    end
    if (cres === 1'h1) resets++;
  end
  always @(dclk) if (!rst_in) clk_edges++;
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  // Notes the pair, then waits for it under a bound.
  task automatic want(input logic [1:0] e, input int lim);
    int i;
    expq.push_back(e);
    for (i = 0; i < lim && {ic, rx} !== e; i++) @(posedge mclk_in);
    if (i == lim) begin
      miscompares++;
      $display("Error wait exp %h got %h", e, {ic, rx});
      end_sim();
    end
  endtask
  task automatic gap(input int ticks);
    cyc(ticks * 8);
    dem <= !dem;
  endtask
  initial begin
    cyc(16);
    rst_in <= 1'h0;
    cyc(300);
    poll_n <= 1'h0;
    want(2'h2, 4000);
    want(2'h3, 200);
    cyc(1300);
    poll_n <= 1'h1;
    want(2'h0, 4000);
    $display("Test poll done");
    dem <= 1'h0;
    cyc(24);
    dem <= 1'h1;
    cyc(800);
    // The preburst starts while asleep, so the check never sees a long gap.
    repeat (2) gap(12);
    cfg.sleep <= 5'h01;
    cfg.check_bit_count <= 2'h1;
    expq.push_back(2'h2);
    expq.push_back(2'h3);
    repeat (8) gap(12);
    chk_state(2'h3, {ic, rx});
    gap(24);
    // Random mix of one double interval or two single intervals per bit.
    repeat (8) begin
      if ($random(seed) & 1) begin
        gap(12);
        gap(12);
      end
      else gap(24);
    end
    cyc(1);
    if (!dem) gap(12);
    cyc(1000);
    chk_count("shift clock edges", 9, clk_edges);
    $display("Test clock done");
    cfg.check_bit_count <= 2'h0;
    pull <= 1'h1;
    cyc(800);
    pull <= 1'h0;
    want(2'h0, 1000);
    want(2'h2, 200);
    want(2'h3, 200);
    pull <= 1'h1;
    cyc(2100);
    pull <= 1'h0;
    want(2'h0, 1000);
    chk_count("config resets", 1, resets);
    $display("Test off done");
    end_sim();
  end
endmodule
`default_nettype wire
